// *** common/dagc_pkg.sv ***
`default_nettype none
package dagc_pkg;
    // ==================================================
    // control word layout
    localparam int WORD_BITS = 16;
    localparam int GAIN_BITS = 5;
    localparam int GAIN_A_LSB = 11;
    localparam int GAIN_B_LSB = 6;
    localparam int SIGNED_BIT = 5;
    localparam int MODE_BIT = 4;
    localparam int SINGLE_BUS_BIT = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
    // ==================================================
    // conversion data path
    localparam int CODE_BITS = 10;
    localparam int STAGES = 5;
    localparam int STAGE_BITS = 2;
    localparam logic [9:0] CODE_RESET = 10'h200;
    // ==================================================
    // output latency in input clock cycles
    localparam int LAT_DUAL_80 = 8;
    localparam int LAT_DUAL_40 = 4;
    localparam int LAT_SINGLE_A = 8;
    localparam int LAT_SINGLE_B = 9;
    localparam int LAT_MAX = 9;
    // apply gains on this falling edge of the conversion clock
    localparam logic [1:0] GAIN_APPLY_FALL = 2'h2;
endpackage
`default_nettype wire

// *** common/dagc_ctl_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface dagc_ctl_if;
    logic [15:0] word;
    logic load;
    logic err;
    modport port (output word, output load, output err);
    modport core (input word, input load, input err);
endinterface
`default_nettype wire

// *** rtl/dagc_serial_port.sv ***
`timescale 1ns/100ps
`default_nettype none
module dagc_serial_port
    import dagc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // synchronised serial pins
    input wire logic cs_n_s,
    input wire logic sclk_s,
    input wire logic sdi_s,
    // towards the core
    dagc_ctl_if.port ctl
);
    logic cs_n_d1_q;
    logic sclk_d1_q;
    logic active_q;
    logic [4:0] count_q;
    logic [15:0] shift_q;
    logic [15:0] word_q;
    logic load_q;
    logic err_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sclk_rise;

    // edge detection on synchronised levels
    assign cs_fall = cs_n_d1_q & ~cs_n_s;
    assign cs_rise = ~cs_n_d1_q & cs_n_s;
    assign sclk_fall = sclk_d1_q & ~sclk_s;
    assign sclk_rise = ~sclk_d1_q & sclk_s;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_n_d1_q <= 1'b1;
            sclk_d1_q <= 1'b1; // parked high, no false rise after reset
        end else begin
            cs_n_d1_q <= cs_n_s;
            sclk_d1_q <= sclk_s;
        end
    end

    // frame and bit counting, msb first shift
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            count_q <= 5'h00;
            shift_q <= 16'h0000;
        end else if (cs_fall) begin
            active_q <= 1'b1;
            count_q <= 5'h00;
        end else if (cs_rise) begin
            active_q <= 1'b0;
        end else if (active_q && sclk_fall && count_q != BIT_COUNT_FULL) begin
            shift_q <= {shift_q[14:0], sdi_s};
            count_q <= count_q + 5'h01;
        end else if (active_q && sclk_rise && count_q == BIT_COUNT_FULL) begin
            active_q <= 1'b0; // word taken, wait for next frame
        end
    end

    // transfer on first rise after 16th fall or on chip select rise
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            word_q <= CTRL_RESET;
            load_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            err_q <= 1'b0;
            if (active_q && count_q == BIT_COUNT_FULL && (sclk_rise || cs_rise)) begin
                word_q <= shift_q;
                load_q <= 1'b1;
            end else if (active_q && cs_rise) begin
                err_q <= 1'b1;
            end
        end
    end

    assign ctl.word = word_q;
    assign ctl.load = load_q;
    assign ctl.err = err_q;
endmodule
`default_nettype wire

// *** rtl/dagc_pipe_corr.sv ***
`timescale 1ns/100ps
`default_nettype none
module dagc_pipe_corr
    import dagc_pkg::*;
#(
    parameter int NSTAGE = STAGES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // one pulse per conversion
    input wire logic step,
    // two bit code of each stage, stage 0 in the top bits
    input wire logic [9:0] stage_codes,
    // corrected result
    output logic [9:0] result
);
    logic [9:0] acc_q [NSTAGE];
    logic [9:0] result_q;

    // stage i holds the sample that entered i steps earlier; each adds
    // its weighted digit so overlapping stage offsets are absorbed
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NSTAGE; i++) begin
                acc_q[i] <= 10'h000;
            end
            result_q <= CODE_RESET;
        end else if (step) begin
            acc_q[0] <= {stage_codes[9:8], 8'h00};
            for (int i = 1; i < NSTAGE; i++) begin
                acc_q[i] <= acc_q[i-1] + (10'(stage_codes[9-2*i -: 2]) << (8 - 2*i));
            end
            result_q <= acc_q[NSTAGE-1];
        end
    end

    assign result = result_q;
endmodule
`default_nettype wire

// *** rtl/dagc_top.sv ***
// Functional notes
// - control word clears to zero at reset
// - load at first rise after sixteenth fall
// - early chip select rise discards the write
// - gains apply on second conversion clock fall
// - format and timing bits apply immediately
// - format bit selects unsigned or two's complement
// - each channel gets its own five bit gain
// - divide 80 MHz input or pass 40 MHz on dual bus
// - conversion clock drives the output data clock except in option D
// - five two-bit stages corrected into ten bits
// - both channels sampled together at clock rise
// - mid-scale unsigned code is 200 hex
// - chip select fall opens msb-first shifting
// - mode and bus bits pick four output options
// - latency 8/4 dual, 8/9 single bus
`timescale 1ns/100ps
`default_nettype none
module dagc_top
    import dagc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial control pins
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_data_in,
    // device input clock pin, 80 or 40 MHz
    input wire logic dev_clk,
    // sub-converter stage digits per channel
    input wire logic [9:0] stage_a,
    input wire logic [9:0] stage_b,
    // amplifier gains
    output logic [4:0] gain_a,
    output logic [4:0] gain_b,
    // configuration in force
    output logic signed_output_select,
    output logic mode,
    output logic single_bus_select,
    output logic write_error,
    // output data
    output logic [9:0] data_a,
    output logic [9:0] data_b,
    output logic [9:0] bus_data,
    output logic bus_chan_b,
    output logic output_data_clock
);
    // ==================================================
    // pin synchronisers
    logic [1:0] cs_sync_q;
    logic [1:0] sclk_sync_q;
    logic [2:0] sdi_sync_q;
    logic [1:0] clk_sync_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cs_sync_q <= 2'h3;
            sclk_sync_q <= 2'h3;
            sdi_sync_q <= 3'h0;
            clk_sync_q <= 2'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[0], cs_n};
            sclk_sync_q <= {sclk_sync_q[0], sclk};
            sdi_sync_q <= {sdi_sync_q[1:0], serial_data_in}; // one extra stage for hold
            clk_sync_q <= {clk_sync_q[0], dev_clk};
        end
    end

    // ==================================================
    // serial port
    dagc_ctl_if ctl ();

    dagc_serial_port u_port (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cs_n_s(cs_sync_q[1]),
        .sclk_s(sclk_sync_q[1]),
        .sdi_s(sdi_sync_q[2]),
        .ctl(ctl.port)
    );

    // ==================================================
    // control word and immediate bits
    logic [15:0] ctrl_q;
    logic err_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (ctl.load) begin
            ctrl_q <= ctl.word;
        end
    end

    // error pulse for an aborted write, word left alone
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else begin
            err_q <= ctl.err;
        end
    end

    logic fmt_signed;
    logic fmt_mode;
    logic fmt_single;
    assign fmt_signed = ctrl_q[SIGNED_BIT];
    assign fmt_mode = ctrl_q[MODE_BIT];
    assign fmt_single = ctrl_q[SINGLE_BUS_BIT];

    // ==================================================
    // input clock edges and internal conversion clock
    logic clk_d_q;
    logic clk_rise;
    logic conv_clk_q;
    logic conv_rise;
    logic conv_fall;
    logic conv_d_q;

    assign clk_rise = ~clk_d_q & clk_sync_q[1];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clk_d_q <= 1'b0;
        end else begin
            clk_d_q <= clk_sync_q[1];
        end
    end

    // 80 MHz input is halved, 40 MHz input passes on dual bus; drives the output data clock outside option D
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            conv_clk_q <= 1'b0;
        end else if (fmt_mode && !fmt_single) begin
            conv_clk_q <= clk_sync_q[1];
        end else if (clk_rise) begin
            conv_clk_q <= ~conv_clk_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            conv_d_q <= 1'b0;
        end else begin
            conv_d_q <= conv_clk_q;
        end
    end

    assign conv_rise = ~conv_d_q & conv_clk_q;
    assign conv_fall = conv_d_q & ~conv_clk_q;

    // ==================================================
    // gain resynchronisation
    logic [4:0] gain_a_q;
    logic [4:0] gain_b_q;
    logic gain_pend_q;
    logic [1:0] fall_cnt_q;

    // a new write restarts the count of falling edges
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gain_pend_q <= 1'b0;
            fall_cnt_q <= 2'h0;
        end else if (ctl.load) begin
            gain_pend_q <= 1'b1;
            fall_cnt_q <= 2'h0;
        end else if (gain_pend_q && conv_fall) begin
            fall_cnt_q <= fall_cnt_q + 2'h1;
            if (fall_cnt_q + 2'h1 == GAIN_APPLY_FALL) begin
                gain_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gain_a_q <= 5'h00;
            gain_b_q <= 5'h00;
        end else if (gain_pend_q && !ctl.load && conv_fall
                     && fall_cnt_q + 2'h1 == GAIN_APPLY_FALL) begin
            gain_a_q <= ctrl_q[GAIN_A_LSB +: GAIN_BITS];
            gain_b_q <= ctrl_q[GAIN_B_LSB +: GAIN_BITS];
        end
    end

    // ==================================================
    // conversion pipelines, both channels on the same rise
    logic [9:0] res_a;
    logic [9:0] res_b;

    dagc_pipe_corr #(.NSTAGE(STAGES)) u_corr_a (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .step(conv_rise),
        .stage_codes(stage_a),
        .result(res_a)
    );

    dagc_pipe_corr #(.NSTAGE(STAGES)) u_corr_b (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .step(conv_rise),
        .stage_codes(stage_b),
        .result(res_b)
    );

    // ==================================================
    // output coding
    logic [9:0] code_a;
    logic [9:0] code_b;
    assign code_a = {res_a[9] ^ fmt_signed, res_a[8:0]};
    assign code_b = {res_b[9] ^ fmt_signed, res_b[8:0]};

    // ==================================================
    // latency line on input clock cycles
    logic [9:0] line_a_q [LAT_MAX];
    logic [9:0] line_b_q [LAT_MAX];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < LAT_MAX; i++) begin
                line_a_q[i] <= CODE_RESET;
                line_b_q[i] <= CODE_RESET;
            end
        end else if (clk_rise) begin
            line_a_q[0] <= code_a;
            line_b_q[0] <= code_b;
            for (int i = 1; i < LAT_MAX; i++) begin
                line_a_q[i] <= line_a_q[i-1];
                line_b_q[i] <= line_b_q[i-1];
            end
        end
    end

    logic [9:0] tap_a;
    logic [9:0] tap_b;

    // tap choice per output option
    always_comb begin
        tap_a = line_a_q[LAT_DUAL_80-1];
        tap_b = line_b_q[LAT_DUAL_80-1];
        if (fmt_single) begin
            tap_a = line_a_q[LAT_SINGLE_A-1];
            tap_b = line_b_q[LAT_SINGLE_B-1];
        end else if (fmt_mode) begin
            tap_a = line_a_q[LAT_DUAL_40-1];
            tap_b = line_b_q[LAT_DUAL_40-1];
        end
    end

    // ==================================================
    // output buses and output data clock
    logic [9:0] data_a_q;
    logic [9:0] data_b_q;
    logic [9:0] bus_q;
    logic chan_b_q;
    logic oclk_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            data_a_q <= CODE_RESET;
            data_b_q <= CODE_RESET;
            bus_q <= CODE_RESET;
            chan_b_q <= 1'b0;
        end else if (clk_rise) begin
            data_a_q <= tap_a;
            data_b_q <= tap_b;
            chan_b_q <= fmt_single & ~chan_b_q;
            // pick by the flag's next value so the flag marks channel b
            bus_q <= (fmt_single && !chan_b_q) ? tap_b : tap_a;
        end
    end

    // option D follows the input clock, the others the 40 MHz clock
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            oclk_q <= 1'b0;
        end else if (fmt_single && fmt_mode) begin
            oclk_q <= clk_sync_q[1];
        end else begin
            oclk_q <= conv_clk_q;
        end
    end

    // ==================================================
    // status registers
    logic signed_q;
    logic mode_q;
    logic single_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            signed_q <= 1'b0;
            mode_q <= 1'b0;
            single_q <= 1'b0;
        end else begin
            signed_q <= fmt_signed;
            mode_q <= fmt_mode;
            single_q <= fmt_single;
        end
    end

    assign gain_a = gain_a_q;
    assign gain_b = gain_b_q;
    assign signed_output_select = signed_q;
    assign mode = mode_q;
    assign single_bus_select = single_q;
    assign write_error = err_q;
    assign data_a = data_a_q;
    assign data_b = data_b_q;
    assign bus_data = bus_q;
    assign bus_chan_b = chan_b_q;
    assign output_data_clock = oclk_q;
endmodule
`default_nettype wire

// *** verif/dagc_top_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// port checks of the control block
module dagc_top_chk
    import dagc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial chip select
    input wire logic cs_n,
    // observed outputs
    input wire logic [4:0] gain_a,
    input wire logic [4:0] gain_b,
    input wire logic signed_output_select,
    input wire logic mode,
    input wire logic single_bus_select,
    input wire logic write_error,
    input wire logic [9:0] data_a,
    input wire logic [9:0] data_b,
    input wire logic output_data_clock
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // word and data come out of reset cleared and mid-scale
    chk_reset_clears: assert property (
        $rose(rst_n) |-> {gain_a, gain_b, signed_output_select, mode, single_bus_select} == 13'h0000)
        else $error("control state not cleared after reset");
    chk_data_mid: assert property (
        $rose(rst_n) |-> data_a == 10'h200 && data_b == 10'h200)
        else $error("output not mid-scale after reset");
    // an aborted write pulses once and changes nothing
    chk_err_pulse: assert property (
        write_error |=> !write_error)
        else $error("error flag longer than one cycle");
    chk_err_nochange: assert property (
        write_error |=> $stable({gain_a, gain_b, signed_output_select, mode, single_bus_select})[*3])
        else $error("aborted write changed the control state");
    chk_err_cause: assert property (
        write_error |-> cs_n && !$past(cs_n, 12))
        else $error("error flag without a closed frame");
    // selects move only at the end of a frame, gains later and on a clock fall
    chk_sel_cause: assert property (
        $changed({signed_output_select, mode, single_bus_select}) |-> !$past(cs_n, 12))
        else $error("selects changed outside a write");
    chk_gain_after_sel: assert property (
        $changed({signed_output_select, mode, single_bus_select}) |-> $stable({gain_a, gain_b})[*8])
        else $error("gains applied together with the selects");
    chk_gain_on_fall: assert property (
        $changed({gain_a, gain_b}) && !(mode && single_bus_select) |-> ##2 !output_data_clock)
        else $error("gains not applied near a conversion clock fall");
endmodule
bind dagc_top dagc_top_chk i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .gain_a(gain_a), .gain_b(gain_b),
    .signed_output_select(signed_output_select), .mode(mode),
    .single_bus_select(single_bus_select), .write_error(write_error),
    .data_a(data_a), .data_b(data_b), .output_data_clock(output_data_clock)
);
`default_nettype wire

// *** verif/dagc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// host driving the serial control port
module dagc_host_model (
    // serial pins
    output logic cs_n,
    output logic sclk,
    output logic serial_data_in
);
    // idle pins, serial clock parked high outside frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        serial_data_in = 1'b0;
    end
    // open a frame and shift nbits msb first, each bit stable around its fall
    task automatic open_frame(input logic [15:0] word, input int nbits);
        cs_n = 1'b0;
        #80;
        for (int i = 0; i < nbits; i++) begin
            serial_data_in = word[15 - i];
            #80;
            sclk = 1'b0;
            #80;
            sclk = 1'b1;
        end
    endtask
    // close the frame; the released data line shows no stale bit
    task automatic close_frame();
        #80;
        cs_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #400;
    endtask
    // complete write of one word
    task automatic send(input logic [15:0] word);
        open_frame(word, 16);
        close_frame();
    endtask
endmodule
`default_nettype wire

// *** verif/dagc_top_test.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// bench of the control and output block
module dagc_top_test
    import dagc_pkg::*;
;
    typedef struct packed {
        logic [15:0] word;
        logic [9:0] stage;
        logic [9:0] exp;
    } dagc_row_t;
    logic ref_clk, rst_n, dev_clk, cs_n, sclk, serial_data_in;
    logic [9:0] stage_a, stage_b, data_a, data_b, bus_data;
    logic [4:0] gain_a, gain_b;
    logic signed_output_select, mode, single_bus_select, write_error, bus_chan_b;
    logic output_data_clock;
    int n_fail, cmp_count, n_err, rises;
    logic side_b;
    dagc_row_t rows [7] = '{'{16'hF800, 10'h200, 10'h200}, '{16'h0560, 10'h200, 10'h000},
        '{16'h5460, 10'h3FF, 10'h1FF}, '{16'h1F00, 10'h000, 10'h000},
        '{16'h0030, 10'h200, 10'h000}, '{16'h0018, 10'h3FF, 10'h3FF},
        '{16'h0008, 10'h000, 10'h000}};
    dagc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
        .serial_data_in(serial_data_in), .dev_clk(dev_clk), .stage_a(stage_a),
        .stage_b(stage_b), .gain_a(gain_a), .gain_b(gain_b),
        .signed_output_select(signed_output_select), .mode(mode),
        .single_bus_select(single_bus_select), .write_error(write_error), .data_a(data_a),
        .data_b(data_b), .bus_data(bus_data), .bus_chan_b(bus_chan_b),
        .output_data_clock(output_data_clock));
    dagc_host_model i_host (.cs_n(cs_n), .sclk(sclk), .serial_data_in(serial_data_in));
    // main clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // device input clock, free running and unrelated in phase
    initial begin
        dev_clk = 1'b0;
        #7;
        forever #80 dev_clk = ~dev_clk;
    end
    // count aborted-write pulses
    always @(posedge ref_clk) begin
        if (write_error === 1'b1) begin
            n_err++;
        end
    end
    // ==================================================
    // helpers
    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({9'h000, got}, {9'h000, exp});
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // rises of the output data clock over four input clock periods
    task automatic count_oclk(output int k);
        logic last;
        k = 0;
        last = output_data_clock;
        repeat (64) begin
            @(posedge ref_clk);
            #1;
            if (!last && output_data_clock === 1'b1) begin
                k++;
            end
            last = output_data_clock;
        end
    endtask
    task automatic check_cfg(input logic [15:0] w);
        chk_val({5'h00, gain_a}, {5'h00, w[15:11]});
        chk_val({5'h00, gain_b}, {5'h00, w[10:6]});
        chk_bit(signed_output_select, w[5]);
        chk_bit(mode, w[4]);
        chk_bit(single_bus_select, w[3]);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #300000;
        n_fail++;
        wrap_up();
    end
    // ==================================================
    // stimulus
    initial begin
        rst_n = 1'b0;
        stage_a = 10'h000;
        stage_b = 10'h000;
        cycles(12);
        rst_n = 1'b1;
        cycles(3);
        // table of ordinary writes and conversions
        foreach (rows[i]) begin
            stage_a = rows[i].stage;
            stage_b = rows[i].stage;
            i_host.send(rows[i].word);
            cycles(400);
            check_cfg(rows[i].word);
            // mode set: output clock at input rate, otherwise half of it
            count_oclk(rises);
            chk_val(10'(rises), rows[i].word[4] ? 10'h004 : 10'h002);
            if (rows[i].word[3]) begin
                chk_val(bus_data, rows[i].exp);
            end else begin
                chk_val(data_a, rows[i].exp);
                chk_val(data_b, rows[i].exp);
            end
        end
        // single bus alternates the channels, the flag marks channel b
        stage_a = 10'h3FF;
        cycles(400);
        side_b = bus_chan_b;
        chk_val(bus_data, side_b ? 10'h000 : 10'h3FF);
        cycles(16);
        chk_bit(bus_chan_b, ~side_b);
        chk_val(bus_data, side_b ? 10'h3FF : 10'h000);
        // load at the sclk rise after the sixteenth fall, chip select still low
        i_host.open_frame(16'h0020, 16);
        cycles(20);
        chk_bit(signed_output_select, 1'b1);
        i_host.close_frame();
        // short frame is refused
        n_err = 0;
        i_host.open_frame(16'hFFF8, 7);
        i_host.close_frame();
        cycles(40);
        chk_val(10'(n_err), 10'h001);
        check_cfg(16'h0020);
        // selects at once, gains only after two conversion clock falls
        i_host.open_frame(16'hFFE0, 16);
        cycles(10);
        chk_bit(signed_output_select, 1'b1);
        chk_val({5'h00, gain_a}, 10'h000);
        i_host.close_frame();
        cycles(100);
        check_cfg(16'hFFE0);
        // reset in mid-run
        rst_n = 1'b0;
        cycles(12);
        check_cfg(16'h0000);
        chk_val(data_a, 10'h200);
        rst_n = 1'b1;
        cycles(3);
        wrap_up();
    end
endmodule
`default_nettype wire
